// file: verilog/isf_status_flags.sv
`timescale 1ns/10ps
module isf_status_flags
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// serial lines, sampled only
	input wire logic scl_in,
	input wire logic sda_in,
	// transfer engine
	input wire isf_pkg::isf_ev_t ev,
	output isf_pkg::isf_eng_t eng,
	// interrupts
	output logic irq,
	output logic err_irq
);

	// ==========================================================
	// address decode
	function automatic isf_pkg::isf_sel_t addr_sel(input logic [11:0] a);
		isf_pkg::isf_sel_t s;
		s = isf_pkg::SEL_NONE;
		if (a == isf_pkg::OFS_CONTROL_ONE)
			s = isf_pkg::SEL_CTL;
		else if (a == isf_pkg::OFS_BYTE_BUFFER)
			s = isf_pkg::SEL_BUF;
		else if (a == isf_pkg::OFS_STATUS_ONE)
			s = isf_pkg::SEL_ST1;
		else if (a == isf_pkg::OFS_STATUS_TWO)
			s = isf_pkg::SEL_ST2;
		else if (a == isf_pkg::OFS_IRQ_STATUS)
			s = isf_pkg::SEL_IST;
		else if (a == isf_pkg::OFS_IRQ_MASK)
			s = isf_pkg::SEL_IMK;
		return s;
	endfunction : addr_sel

	logic aw_have_reg;
	logic [11:0] aw_addr_reg;
	logic w_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic wr_fire;
	logic rd_fire;
	isf_pkg::isf_sel_t wr_sel;
	isf_pkg::isf_sel_t rd_sel;

	logic [15:0] control_reg;
	logic [7:0] buffer_reg;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] irq_stat_reg;
	logic [15:0] irq_mask_reg;
	logic sr1_armed_reg;
	logic resend_reg;
	logic busy_reg;

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_old_reg;
	logic sda_old_reg;
	logic start_det;
	logic stop_det;

	logic on;
	logic hold_off;

	// ==========================================================
	// bus handshakes: address and data taken in either order
	assign awready = ~aw_have_reg & ~bvalid_reg;
	assign wready = ~w_have_reg & ~bvalid_reg;
	assign arready = ~rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign rd_fire = arvalid & ~rvalid_reg;
	assign wr_sel = addr_sel(aw_addr_reg);
	assign rd_sel = addr_sel(araddr);

	assign on = control_reg[isf_pkg::CTL_ON_BIT];
	assign hold_off = control_reg[isf_pkg::CTL_HOLD_OFF_BIT];

	// write address and data holding
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			else if (wr_fire)
				aw_have_reg <= 1'b0;
			if (wvalid && wready)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			else if (wr_fire)
				w_have_reg <= 1'b0;
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= isf_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_sel == isf_pkg::SEL_NONE) ? isf_pkg::RESP_SLVERR : isf_pkg::RESP_OKAY;
		end
		else if (bready)
			bvalid_reg <= 1'b0;
	end

	// read data, captured when the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= isf_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= isf_pkg::RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			if (rd_sel == isf_pkg::SEL_CTL)
				rdata_reg <= {16'h0000, control_reg};
			else if (rd_sel == isf_pkg::SEL_BUF)
				rdata_reg <= {24'h00_0000, buffer_reg};
			else if (rd_sel == isf_pkg::SEL_ST1)
				rdata_reg <= {16'h0000, flags_reg & isf_pkg::FLAG_MASK};
			else if (rd_sel == isf_pkg::SEL_ST2)
				rdata_reg <= {29'h0000_0000, ev.transmitter, busy_reg, ev.master};
			else if (rd_sel == isf_pkg::SEL_IST)
				rdata_reg <= {16'h0000, irq_stat_reg};
			else if (rd_sel == isf_pkg::SEL_IMK)
				rdata_reg <= {16'h0000, irq_mask_reg};
			else
				rresp_reg <= isf_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid_reg <= 1'b0;
	end

	// ==========================================================
	// serial line sampling and start/stop detection
	// the link clock is only seen as levels, so both lines go through two stages
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_old_reg <= 1'b1;
			sda_old_reg <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_old_reg <= scl_sync_reg[1];
			sda_old_reg <= sda_sync_reg[1];
		end
	end

	// data edges while the clock line stays high are conditions
	assign start_det = scl_old_reg & scl_sync_reg[1] & sda_old_reg & ~sda_sync_reg[1];
	assign stop_det = scl_old_reg & scl_sync_reg[1] & ~sda_old_reg & sda_sync_reg[1];

	// bus busy between a start and a stop, kept even while disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			busy_reg <= 1'b0;
		else if (start_det)
			busy_reg <= 1'b1;
		else if (stop_det)
			busy_reg <= 1'b0;
	end

	// ==========================================================
	// control, mask and byte buffer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			control_reg <= isf_pkg::CONTROL_RESET;
			irq_mask_reg <= isf_pkg::MASK_RESET;
		end
		else if (wr_fire)
		begin
			if (wr_sel == isf_pkg::SEL_CTL)
			begin
				if (w_strb_reg[0])
					control_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					control_reg[15:8] <= w_data_reg[15:8];
			end
			else if (wr_sel == isf_pkg::SEL_IMK)
			begin
				if (w_strb_reg[0])
					irq_mask_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					irq_mask_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end

	// software write loads the next byte to send; a received byte lands only if room
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			buffer_reg <= isf_pkg::BUFFER_RESET;
		else if (wr_fire && wr_sel == isf_pkg::SEL_BUF && w_strb_reg[0])
			buffer_reg <= w_data_reg[7:0];
		else if (on && ev.byte_rcvd && !flags_reg[isf_pkg::F_RXF])
			buffer_reg <= ev.rx_data;
	end

	// ==========================================================
	// two-step clear tracking: armed by a status one read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sr1_armed_reg <= 1'b0;
		else if (!on)
			sr1_armed_reg <= 1'b0;
		else if (rd_fire && rd_sel == isf_pkg::SEL_ST1)
			sr1_armed_reg <= 1'b1;
		else if (rd_fire || wr_fire)
			sr1_armed_reg <= 1'b0;
	end

	// ==========================================================
	// flag set conditions
	always_comb
	begin
		flag_set = 16'h0000;
		flag_set[isf_pkg::F_START] = ev.start_gen;
		flag_set[isf_pkg::F_ADDR] = (ev.master & ev.addr_acked)
			| (~ev.master & ev.addr_match);
		flag_set[isf_pkg::F_HDR] = ev.master & ev.header_sent;
		flag_set[isf_pkg::F_STOP] = ~ev.master & ev.ack_seen & stop_det;
		flag_set[isf_pkg::F_TXE] = ev.tx_taken;
		flag_set[isf_pkg::F_RXF] = ev.byte_rcvd & ~flags_reg[isf_pkg::F_RXF];
		// held clock: the engine waits on this flag instead of losing a byte
		flag_set[isf_pkg::F_BYTE] = ~hold_off
			& ((ev.tx_need & flags_reg[isf_pkg::F_TXE])
			| (ev.byte_rcvd & flags_reg[isf_pkg::F_RXF]));
		flag_set[isf_pkg::F_BUS_ERROR_FLAG] = ev.in_byte & (start_det | stop_det);
		flag_set[isf_pkg::F_ARBITRATION_LOST_FLAG] = ev.arb_lost;
		flag_set[isf_pkg::F_AF] = ev.ack_missing;
		flag_set[isf_pkg::F_OVR] = hold_off
			& ((ev.tx_need & flags_reg[isf_pkg::F_TXE])
			| (ev.byte_rcvd & flags_reg[isf_pkg::F_RXF]));
		flag_set[isf_pkg::F_PEC] = ev.pec_nack;
	end

	// ==========================================================
	// flag clear conditions
	always_comb
	begin
		flag_clr = 16'h0000;
		// write zero clears, write one leaves the flag as it is
		if (wr_fire && wr_sel == isf_pkg::SEL_ST1)
		begin
			if (w_strb_reg[0])
				flag_clr[7:0] = ~w_data_reg[7:0] & isf_pkg::W0_MASK[7:0];
			if (w_strb_reg[1])
				flag_clr[15:8] = ~w_data_reg[15:8] & isf_pkg::W0_MASK[15:8];
		end
		if (wr_fire && wr_sel == isf_pkg::SEL_BUF)
		begin
			flag_clr[isf_pkg::F_TXE] = 1'b1;
			flag_clr[isf_pkg::F_RXF] = 1'b1;
			flag_clr[isf_pkg::F_START] = sr1_armed_reg;
			flag_clr[isf_pkg::F_HDR] = sr1_armed_reg;
			flag_clr[isf_pkg::F_BYTE] = sr1_armed_reg;
		end
		if (rd_fire && rd_sel == isf_pkg::SEL_BUF)
		begin
			flag_clr[isf_pkg::F_RXF] = 1'b1;
			flag_clr[isf_pkg::F_BYTE] = sr1_armed_reg;
		end
		if (rd_fire && rd_sel == isf_pkg::SEL_ST2)
			flag_clr[isf_pkg::F_ADDR] = sr1_armed_reg;
		if (wr_fire && wr_sel == isf_pkg::SEL_CTL)
			flag_clr[isf_pkg::F_STOP] = sr1_armed_reg;
		if (start_det || stop_det)
		begin
			flag_clr[isf_pkg::F_TXE] = 1'b1;
			if (ev.transmitter)
				flag_clr[isf_pkg::F_BYTE] = 1'b1;
		end
	end

	// new events win over any clear in the same cycle; disabling wipes everything
	always_comb
	begin
		flags_next = ((flags_reg & ~flag_clr) | flag_set) & isf_pkg::FLAG_MASK;
		if (!on)
			flags_next = isf_pkg::STATUS_RESET;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_reg <= isf_pkg::STATUS_RESET;
		else
			flags_reg <= flags_next;
	end

	// ==========================================================
	// sticky event status, cleared by its own read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_stat_reg <= isf_pkg::STATUS_RESET;
		else if (rd_fire && rd_sel == isf_pkg::SEL_IST)
			irq_stat_reg <= flags_next & ~flags_reg; // set wins over the read clear
		else
			irq_stat_reg <= irq_stat_reg | (flags_next & ~flags_reg);
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// error line follows the error flags as levels
	assign err_irq = control_reg[isf_pkg::CTL_ERR_IRQ_BIT]
		& |(flags_reg & isf_pkg::ERR_MASK);

	// ==========================================================
	// engine controls
	// underrun with clock holding off: the old buffer byte simply goes out again
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			resend_reg <= 1'b0;
		else
			resend_reg <= on & hold_off & ev.tx_need & flags_reg[isf_pkg::F_TXE];
	end

	always_comb
	begin
		eng.tx_data = buffer_reg;
		eng.tx_resend = resend_reg;
		eng.hold_clock = flags_reg[isf_pkg::F_BYTE] & ~hold_off;
		eng.interface_on = on;
	end

endmodule : isf_status_flags

// file: verilog/isf_pkg.sv
// Contract
// - set packet-check error (bit 12) on checksum mismatch answered by not-acknowledge.
// - clock holding off, byte arriving into unread buffer is dropped, overrun (bit 11) set.
// - clock holding off, no new byte to send: resend previous byte, set overrun.
// - set ack-failure (bit 10) on missing acknowledge; write zero or disable clears.
// - set arbitration-lost (bit 9) on lost arbitration; write zero or disable clears.
// - set bus-error (bit 8) on misplaced start or stop; write zero or disable clears.
// - tx-empty (bit 7) while buffer empty; buffer write, start, stop, disable clear.
// - rx-full (bit 6) while buffer unread; buffer read or write, disable clear.
// - slave stop after acknowledge sets stop-seen (bit 4); status read then control write clears.
// - master ten-bit header sent sets bit 3; status read then buffer write clears.
// - clock holding on, byte done (bit 2) on send underrun or receive into unread buffer.
// - status read then buffer access clears byte done; so do start/stop sending, disable.
// - master sets address-done (bit 1) after acknowledge of final address byte.
// - slave sets address-done only on a matching received address.
// - status one read then status two read, or disable, clears address-done.
// - start generated sets bit 0; status read then buffer write, or disable, clears.
// - error interrupt while enabled and any of the five error flags is set.
package isf_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CONTROL_ONE = 12'h000;
	localparam logic [11:0] OFS_BYTE_BUFFER = 12'h010;
	localparam logic [11:0] OFS_STATUS_ONE = 12'h014;
	localparam logic [11:0] OFS_STATUS_TWO = 12'h018;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h024;

	// ==========================================================
	// field positions
	localparam int CTL_ON_BIT = 0;
	localparam int CTL_HOLD_OFF_BIT = 7;
	localparam int CTL_ERR_IRQ_BIT = 8;
	localparam int F_START = 0;
	localparam int F_ADDR = 1;
	localparam int F_BYTE = 2;
	localparam int F_HDR = 3;
	localparam int F_STOP = 4;
	localparam int F_RXF = 6;
	localparam int F_TXE = 7;
	localparam int F_BUS_ERROR_FLAG = 8;
	localparam int F_ARBITRATION_LOST_FLAG = 9;
	localparam int F_AF = 10;
	localparam int F_OVR = 11;
	localparam int F_PEC = 12;
	localparam int S2_MASTER = 0;
	localparam int S2_BUSY = 1;
	localparam int S2_TRANSMIT = 2;
	localparam logic [15:0] ERR_MASK = 16'h1f00;
	localparam logic [15:0] FLAG_MASK = 16'h1fdf;
	localparam logic [15:0] W0_MASK = 16'h1f02;

	// ==========================================================
	// reset values
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [7:0] BUFFER_RESET = 8'h00;
	localparam logic [15:0] MASK_RESET = 16'h0000;

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_CTL = 3'b001,
		SEL_BUF = 3'b011,
		SEL_ST1 = 3'b010,
		SEL_ST2 = 3'b110,
		SEL_IST = 3'b111,
		SEL_IMK = 3'b101
	} isf_sel_t;

	// events from the transfer engine, one-cycle pulses except rx_data and the last four, which are levels
	typedef struct packed {
		logic start_gen;
		logic addr_acked;
		logic addr_match;
		logic header_sent;
		logic tx_taken;
		logic tx_need;
		logic byte_rcvd;
		logic [7:0] rx_data;
		logic ack_missing;
		logic arb_lost;
		logic pec_nack;
		logic master;
		logic transmitter;
		logic ack_seen;
		logic in_byte;
	} isf_ev_t;

	// controls back to the transfer engine
	typedef struct packed {
		logic [7:0] tx_data;
		logic tx_resend;
		logic hold_clock;
		logic interface_on;
	} isf_eng_t;

endpackage : isf_pkg

// file: verif/isf_checker.sv
`timescale 1ns/10ps
module isf_checker
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus, observed
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic bvalid,
	// engine side and interrupt
	input wire isf_pkg::isf_ev_t ev,
	input wire isf_pkg::isf_eng_t eng,
	input wire logic err_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// flag effects seen at the engine side
	err_off_a: assert property (!eng.interface_on && !$past(eng.interface_on) |-> !err_irq)
		else $error("error interrupt while disabled");
	err_rise_a: assert property ($rose(err_irq) |-> $past(ev.ack_missing || ev.arb_lost
		|| ev.pec_nack || ev.byte_rcvd || ev.tx_need || ev.in_byte) || $rose(bvalid))
		else $error("error interrupt without cause");
	resend_cause_a: assert property (eng.tx_resend |-> $past(ev.tx_need && eng.interface_on))
		else $error("resend without need");
	resend_pulse_a: assert property (eng.tx_resend |=> !eng.tx_resend)
		else $error("resend longer than one cycle");
	hold_off_a: assert property (!eng.interface_on && !$past(eng.interface_on) |-> !eng.hold_clock)
		else $error("clock held while disabled");
	hold_rise_a: assert property ($rose(eng.hold_clock)
		|-> $past(ev.byte_rcvd || ev.tx_need) || $rose(bvalid))
		else $error("clock hold without byte event");
	// the buffer only moves on a stored byte or a register write
	data_src_a: assert property ($changed(eng.tx_data) |-> $past(ev.byte_rcvd) || $rose(bvalid))
		else $error("buffer changed without cause");

	// ==========================================================
	// register reads
	reserved_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
endmodule : isf_checker

bind isf_status_flags isf_checker chk
(
	.aclk(aclk),
	.aresetn(aresetn),
	.arvalid(arvalid),
	.arready(arready),
	.rvalid(rvalid),
	.rdata(rdata),
	.bvalid(bvalid),
	.ev(ev),
	.eng(eng),
	.err_irq(err_irq)
);

// file: verif/isf_station.sv
`timescale 1ns/10ps
// ==========================================================
// another station on the lines, which rest high through pull-ups
module isf_station
(
	// serial lines
	output logic scl,
	output logic sda
);
	// released lines read high
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// start: data falls while the clock is high, half of a 160 ns period a step
	// steps land on block clock edges, so they are non-blocking to avoid a sampling race
	task automatic start_cond;
		#80 sda <= 1'b0;
		#80 scl <= 1'b0;
	endtask : start_cond

	// stop: data rises while the clock is high, lines then rest released
	task automatic stop_cond;
		#80 sda <= 1'b0;
		#80 scl <= 1'b1;
		#80 sda <= 1'b1;
	endtask : stop_cond
endmodule : isf_station

// file: verif/test_i2c_status_flag_logic.sv
`timescale 1ns/10ps
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
		end \
	end
module test_i2c_status_flag_logic;
	logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
	logic awready, wready, arready, irq, err_irq, scl, sda;
	logic [1:0] bresp, rresp, resp;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	isf_pkg::isf_ev_t ev, lv;
	isf_pkg::isf_eng_t eng;
	int n_fail = 0;
	int check_count = 0;
	localparam logic [11:0] CTL = isf_pkg::OFS_CONTROL_ONE;
	localparam logic [11:0] BUF = isf_pkg::OFS_BYTE_BUFFER;
	localparam logic [11:0] ST1 = isf_pkg::OFS_STATUS_ONE;
	localparam logic [11:0] ST2 = isf_pkg::OFS_STATUS_TWO;

	// ==========================================================
	// block, far station and clock
	isf_station stn (.scl(scl), .sda(sda));
	isf_status_flags uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.scl_in(scl), .sda_in(sda), .ev(ev), .eng(eng), .irq(irq), .err_irq(err_irq));
	// 50 MHz
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// run is about 300 cycles, so 20000 cycles means a hang
	initial
	begin
		#400000;
		n_fail++;
		stop_test;
	end

	// ==========================================================
	// bus and event tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	// each half is held until its own ready, bready until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		// no cycle limit here: only the watchdog ends a wait
		while (!tb)
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(negedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		logic ta, tv;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tv = 1'b0;
		while (!tv)
		begin
			@(negedge aclk);
			ta = arvalid & arready;
			tv = rvalid;
			rd_v = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(negedge aclk);
	endtask : rd
	task automatic chk_st(input logic [15:0] e);
		rd(ST1);
		`CHK(rd_v, {16'h0000, e})
	endtask : chk_st
	// one-cycle event pulse on top of the held levels
	task automatic fire(input int k, input logic [7:0] d);
		isf_pkg::isf_ev_t e;
		e = lv;
		case (k)
			0: e.start_gen = 1'b1;
			1: e.addr_acked = 1'b1;
			2: e.addr_match = 1'b1;
			3: e.header_sent = 1'b1;
			4: e.tx_taken = 1'b1;
			5: e.tx_need = 1'b1;
			6: e.byte_rcvd = 1'b1;
			7: e.ack_missing = 1'b1;
			8: e.arb_lost = 1'b1;
			default: e.pec_nack = 1'b1;
		endcase
		e.rx_data = d;
		@(posedge aclk);
		ev <= e;
		@(posedge aclk);
		ev <= lv;
		@(negedge aclk);
	endtask : fire
	// levels: master, transmitter, ack seen, inside a byte
	task automatic levels(input logic [3:0] v);
		lv.master = v[3];
		lv.transmitter = v[2];
		lv.ack_seen = v[1];
		lv.in_byte = v[0];
		@(posedge aclk);
		ev <= lv;
	endtask : levels

	// ==========================================================
	// scenarios
	task automatic t_errors;
		logic [15:0] tb [3] = '{16'h0400, 16'h0200, 16'h1000};
		for (int k = 0; k < 3; k++)
		begin
			fire(k + 7, 8'h00);
			`CHK(err_irq, 1'b1)
			wr(ST1, 32'h0000_ffff);
			chk_st(tb[k]);
			wr(ST1, {16'h0000, ~tb[k]});
			chk_st(16'h0000);
		end
		levels(4'b0001);
		stn.start_cond;
		repeat (6) @(posedge aclk);
		chk_st(16'h0100);
		wr(ST1, 32'h0000_feff);
		levels(4'b0000);
	endtask : t_errors
	task automatic t_rx;
		fire(6, 8'h5a);
		chk_st(16'h0040);
		fire(6, 8'ha5);
		`CHK(eng.hold_clock, 1'b1)
		chk_st(16'h0044);
		rd(BUF);
		`CHK(rd_v, 32'h0000_005a)
		chk_st(16'h0000);
		wr(CTL, 32'h0000_0181);
		fire(6, 8'h11);
		fire(6, 8'h22);
		chk_st(16'h0840);
		rd(BUF);
		`CHK(rd_v, 32'h0000_0011)
		wr(ST1, 32'h0000_f7ff);
	endtask : t_rx
	task automatic t_tx;
		fire(4, 8'h00);
		chk_st(16'h0080);
		fire(5, 8'h00);
		`CHK(eng.tx_resend, 1'b1)
		chk_st(16'h0880);
		wr(BUF, 32'h0000_003c);
		`CHK(eng.tx_data, 8'h3c)
		chk_st(16'h0800);
		wr(ST1, 32'h0000_f7ff);
		wr(CTL, 32'h0000_0101);
		fire(4, 8'h00);
		fire(5, 8'h00);
		chk_st(16'h0084);
		wr(BUF, 32'h0000_0077);
		`CHK(eng.hold_clock, 1'b0)
	endtask : t_tx
	task automatic t_addr;
		levels(4'b1000);
		fire(0, 8'h00);
		fire(3, 8'h00);
		chk_st(16'h0009);
		wr(BUF, 32'h0000_0001);
		fire(1, 8'h00);
		rd(ST2);
		chk_st(16'h0002);
		rd(ST2);
		chk_st(16'h0000);
		levels(4'b0000);
		fire(2, 8'h00);
		chk_st(16'h0002);
		rd(ST2);
		chk_st(16'h0000);
	endtask : t_addr
	task automatic t_stop;
		levels(4'b0010);
		stn.stop_cond;
		repeat (6) @(posedge aclk);
		chk_st(16'h0010);
		wr(CTL, 32'h0000_0101);
		chk_st(16'h0000);
	endtask : t_stop
	task automatic t_irq;
		rd(isf_pkg::OFS_IRQ_STATUS);
		fire(0, 8'h00);
		`CHK(irq, 1'b0)
		wr(isf_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		`CHK(irq, 1'b1)
		rd(isf_pkg::OFS_IRQ_STATUS);
		`CHK(rd_v, 32'h0000_0001)
		`CHK(irq, 1'b0)
	endtask : t_irq
	task automatic t_disable;
		fire(8, 8'h00);
		fire(6, 8'h42);
		// error interrupt stays enabled, so only the flag wipe can drop the line
		wr(CTL, 32'h0000_0100);
		`CHK(eng.interface_on, 1'b0)
		chk_st(16'h0000);
		`CHK(err_irq, 1'b0)
		fire(7, 8'h00);
		chk_st(16'h0000);
		`CHK(err_irq, 1'b0)
	endtask : t_disable

	// ==========================================================
	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = '0;
		ev = '0;
		lv = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk_st(16'h0000);
		rd(12'h0fc);
		`CHK(resp, isf_pkg::RESP_SLVERR)
		wr(12'h0fc, 32'hffff_ffff);
		`CHK(resp, isf_pkg::RESP_SLVERR)
		wr(CTL, 32'h0000_0101);
		t_errors;
		t_rx;
		t_tx;
		t_addr;
		t_stop;
		t_irq;
		t_disable;
		stop_test;
	end
endmodule : test_i2c_status_flag_logic
